// file: dv/dek_au_model.sv
/*
 Arithmetic unit model that answers the kernel's add requests.
 Assumes the kernel's clock and reset; dly sets how slowly it answers.
*/
`timescale 1ns/100ps
module dek_au_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic au_req,
  input wire logic [2:0] au_op,
  input wire logic [31:0] au_a,
  input wire logic [31:0] au_b,
  input wire logic [3:0] dly,
  output logic [31:0] au_res,
  output logic au_ack,
  output logic [2:0] last_op
);
  logic [3:0] cnt_ff;
  // The result is scrambled outside the answer cycle so a stale value is never reused.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= 4'h0;
      au_ack <= 1'b0;
      au_res <= 32'h0;
      last_op <= 3'h0;
    end else if (au_req && !au_ack && cnt_ff == dly) begin
      cnt_ff <= 4'h0;
      au_ack <= 1'b1;
      au_res <= au_a + au_b;
      last_op <= au_op;
    end else begin
      cnt_ff <= (au_req && !au_ack) ? cnt_ff + 4'h1 : 4'h0;
      au_ack <= 1'b0;
      au_res <= ~au_res;
    end
  end
endmodule : dek_au_model

// file: dv/descriptor_evaluation_kernel_test.sv
/*
 Self-checking bench of the kernel with the arithmetic unit model.
 Assumes descriptors are loaded into buffer entries 0 and 1 over the register bus.
*/
`timescale 1ns/100ps
`include "dek_consts.svh"
module descriptor_evaluation_kernel_test;
  logic clk = 1'b0, nrst = 1'b0, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic l1_acc = 1'b0, l1_wr = 1'b0, ack_o, au_req, au_ack, fault_call, busy, done, term_valid;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, au_a, au_b, au_res;
  logic [3:0] sel_i = 4'hF, dly = 4'h0;
  logic [2:0] au_op, last_op;
  logic [15:0] fault_name, last_fault = 16'h0;
  dek_pkg::dek_term_s term_ref;
  int n_fail = 0, compares = 0, cyc_cnt = 0, n_term = 0;
  dek_kernel i_dut (.clk, .nrst, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i,
    .ack_o, .au_req, .au_op, .au_a, .au_b, .au_res, .au_ack, .l1_acc, .l1_wr, .fault_call,
    .fault_name, .busy, .done, .term_valid, .term_ref);
  dek_au_model i_au (.clk, .nrst, .au_req, .au_op, .au_a, .au_b, .dly, .au_res, .au_ack,
    .last_op);
  // ************************
  // Tasks
  // ************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Called just after a rising edge; ack and read data are taken at the edge that sees ack.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic ld(input logic [31:0] hi, input logic [31:0] nx);
    logic [31:0] q;
    wb(`DEK_A_BIDX, 1'b1, 32'h0, q);
    wb({`DEK_A_BUF, 4'hC}, 1'b1, hi, q);
    wb({`DEK_A_BUF, 4'h8}, 1'b1, nx, q);
  endtask : ld
  // Clears sticky status, starts on entry 0 and counts busy cycles after the start edge.
  task automatic run(input logic [2:0] m, input logic l, output int n,
    output logic [31:0] st);
    logic [31:0] q;
    wb(`DEK_A_STAT, 1'b1, 32'h1E, q);
    wb(`DEK_A_CTRL, 1'b1, {27'h0, l, m, 1'b1}, q);
    n = 0;
    while (busy === 1'b1) begin
      n++;
      @(posedge clk);
    end
    wb(`DEK_A_STAT, 1'b0, 32'h0, st);
  endtask : run
  task automatic t_reset;
    logic [31:0] q;
    wb(`DEK_A_STAT, 1'b0, 32'h0, q);
    chk("status", 32'h0, q);
    wb(8'hFC, 1'b1, 32'hFFFF_FFFF, q);
    wb(8'hFC, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset finished");
  endtask : t_reset
  task automatic t_flow;
    int n;
    logic [31:0] st;
    ld(32'h1010_0000, 32'h0);
    run(3'h0, 1'b0, n, st);
    chk("cycles", 32'h5, 32'(n));
    chk("status", 32'h2, {27'h0, st[4:0]});
    chk("atype", 32'h1, {30'h0, term_ref.atype});
    chk("term pulses", 32'h1, 32'(n_term));
    run(3'h3, 1'b0, n, st);
    chk("status", 32'hA, {27'h0, st[4:0]});
    run(3'h4, 1'b1, n, st);
    chk("status", 32'h2, {27'h0, st[4:0]});
    ld(32'h1000_0000, 32'h0);
    run(3'h0, 1'b0, n, st);
    chk("status", 32'h6, {27'h0, st[4:0]});
    $display("test flow finished");
  endtask : t_flow
  task automatic t_seg;
    int n;
    logic [31:0] st, q;
    ld(32'h1011_5A1C, 32'h3000_0000);
    run(3'h0, 1'b0, n, st);
    wb(`DEK_A_COL23, 1'b0, 32'h0, q);
    chk("segment", 32'h5A, {24'h0, q[31:24]});
    chk("ref seg", 32'h5A, {24'h0, term_ref.col2[15:8]});
    $display("test segment finished");
  endtask : t_seg
  task automatic t_modes;
    int n;
    logic [31:0] st;
    ld(32'h1013_2300, 32'h0);
    for (int m = 0; m < 3; m++) begin
      dly <= 4'(m * 3);
      run(3'(m), 1'b0, n, st);
      chk("au op", 32'(m), {29'h0, last_op});
      chk("length", 32'h3, term_ref.cln);
    end
    $display("test modes finished");
  endtask : t_modes
  // Entry 0 calls entry 1, ends on a descriptor type and so branches to entry 1.
  task automatic t_nest;
    int n;
    logic [31:0] st, q;
    wb(`DEK_A_BIDX, 1'b1, 32'h1, q);
    wb({`DEK_A_BUF, 4'hC}, 1'b1, 32'h50AB_CD13, q);
    wb({`DEK_A_BUF, 4'h8}, 1'b1, 32'h1200_0000, q);
    ld(32'h8123_4120, 32'h0010_0000);
    run(3'h0, 1'b0, n, st);
    chk("status", 32'h2, {27'h0, st[4:0]});
    chk("branch fault", 32'h1234, {16'h0, last_fault});
    chk("ref atype", 32'h1, {30'h0, term_ref.atype});
    chk("ref start", 32'h1, term_ref.cst);
    chk("ref length", 32'h2, term_ref.cln);
    chk("ref col0", 32'h4000, {16'h0, term_ref.col0});
    l1_acc <= 1'b1;
    l1_wr <= 1'b1;
    @(posedge clk);
    l1_acc <= 1'b0;
    repeat (3) @(posedge clk);
    chk("store fault", 32'hABCD, {16'h0, last_fault});
    $display("test nest finished");
  endtask : t_nest
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // ************************
  // Sequence
  // ************************
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    n_term <= n_term + (term_valid === 1'b1);
    if (fault_call === 1'b1) begin
      last_fault <= fault_name;
    end
    if (cyc_cnt == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_flow;
    t_seg;
    t_modes;
    t_nest;
    complete_run;
  end
endmodule : descriptor_evaluation_kernel_test

// file: rtl/dek_consts.svh
/*
 Register offsets, field codes, widths and sizes of the descriptor evaluation kernel.
 Assumes a Wishbone slave with an 8-bit byte address and 32-bit data.
*/
`ifndef DEK_CONSTS_SVH
`define DEK_CONSTS_SVH
`define DEK_A_CTRL 8'h00
`define DEK_A_STAT 8'h04
`define DEK_A_BIDX 8'h08
`define DEK_A_BUF 4'h1
`define DEK_A_CST 8'h20
`define DEK_A_CLN 8'h24
`define DEK_A_COL01 8'h28
`define DEK_A_COL23 8'h2C
`define DEK_A_ECR 8'h30
`define DEK_ET_END 4'h0
`define DEK_ET_SEG 4'h1
`define DEK_ET_CALL 4'h2
`define DEK_AT_DESC 2'h0
`define DEK_AT_PROG 2'h2
`define DEK_MODE_LIST 3'h3
`define DEK_HDR_W 6'h04
`define DEK_SEG_W 6'h08
`define DEK_NAME_W 6'h10
`define DEK_CS_DEPTH 3'h4
`define DEK_AS_DEPTH 3'h4
`define DEK_S_CST 0
`define DEK_S_CLN 1
`define DEK_S_EST 2
`define DEK_S_ELN 3
`endif

// file: rtl/dek_kernel.sv
/*
 Descriptor evaluation kernel: local descriptor buffer, attribute stacks, control stack,
 evaluation sequencer and a classic Wishbone register slave.
 Assumes the arithmetic unit and level-1 access logic run on the same clock.
*/
// Contract
// - Five modes: reference, allocate, deallocate, reset and list reference, passed to the arithmetic unit.
// - The resolved descriptor is fetched into the descriptor register before evaluation.
// - Reset and list reference modes are accepted only for list structures.
// - Unpack four leading bits, then copy remaining attributes into control register.
// - Attributes of the first descriptor of an evaluation are kept.
// - Descriptor-type attributes branch to the computed location and overwrite attributes.
// - Fault procedure names found are copied in, later ones replace earlier.
// - A descriptor naming no fault procedure leaves held names unchanged.
// - Fault procedures fire on level-1 fetch or store, or at branch.
// - The branch clears all fault procedure entries.
// - Copy parameter field length and allocate flag into the control register.
// - A clear allocate flag halts evaluation and sets an allocate fault.
// - Load each expression type, push its parameters onto arithmetic stacks.
// - Segment number is stored only while the segment entry is empty.
// - A call pushes the control register and restarts on the named descriptor.
// - The end delimiter pops the control stack and resumes a nested descriptor.
// - Otherwise a terminal reference is formed and the next operator may run.
// - Collection stack: four 16-bit words of flags, format, segment, names.
// - Four arithmetic stacks of four 32-bit words, calculations via arithmetic unit.
// - Element stacks end empty; container stacks hold the partial reference.
// - A four-bit expression type register holds the current expression type.
// - The local buffer is 32 words of 128 bits.
// - Leading read and write fault bits select the fault procedure to call.
// - A segment expression always carries an 8-bit parameter.
`timescale 1ns/100ps
`include "dek_consts.svh"
module dek_kernel (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic au_req,
  output logic [2:0] au_op,
  output logic [31:0] au_a,
  output logic [31:0] au_b,
  input wire logic [31:0] au_res,
  input wire logic au_ack,
  input wire logic l1_acc,
  input wire logic l1_wr,
  output logic fault_call,
  output logic [15:0] fault_name,
  output logic busy,
  output logic done,
  output logic term_valid,
  output dek_pkg::dek_term_s term_ref
);
  // ****************************************
  // Functions
  // ****************************************
  // Fields are packed from the most significant bit of the descriptor downward.
  function automatic logic [31:0] fld(input logic [127:0] d, input logic [6:0] p,
                                      input logic [5:0] w);
    logic [127:0] s;
    s = d << p;
    fld = s[127:96] >> (6'h20 - w);
  endfunction : fld

  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int k = 0; k < 4; k++) begin
      o[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
    end
    wmask = o;
  endfunction : wmask

  // ****************************************
  // Declarations
  // ****************************************
  dek_pkg::dek_state_e state_ff;
  dek_pkg::dek_ctl_s ctl_ff;
  dek_pkg::dek_ctl_s cstk_ff [0:3];
  logic [2:0] csp_ff;
  logic first_ff;
  logic [3:0] et_ff;
  logic [127:0] desc_ff;
  logic [127:0] bmem [0:31];
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [2:0] mode_ff;
  logic list_ff;
  logic [4:0] loc_ff, bidx_ff;
  logic col_r_ff, col_w_ff, seg_full_ff, fmt_full_ff;
  logic [2:0] dfmt_ff;
  logic [7:0] seg_ff;
  logic [15:0] rd_nm_ff, wr_nm_ff;
  logic done_s_ff, afault_ff, mfault_ff, ofault_ff;
  logic [31:0] as_top [0:3];
  logic [2:0] as_sp [0:3];
  logic [3:0] as_push, as_pop, as_wtop;
  logic [31:0] as_din [0:3];
  logic [31:0] f_hdr, f_ll, f_rd, f_wr, f_se, f_et, f_seg, f_nm, f_es, f_el, rd_c;
  logic [6:0] alen_c, p_wr_c, p_se_c;
  logic [5:0] plen_c;
  logic [15:0] w0_c, w1_c, w2_c, w3_c;
  logic wb_req, wb_wr, start_go, mfault_c, branch_c, generic_c, call_ovf_c;

  // ****************************************
  // Register slave
  // ****************************************
  assign wb_req = cyc_i && stb_i;
  // Writes act on the edge where the master sees ack, so a held request acts once.
  assign wb_wr = wb_req && we_i && ack_ff;
  assign start_go = wb_wr && adr_i == `DEK_A_CTRL && sel_i[0] && dat_i[0]
                    && state_ff == dek_pkg::S_IDLE;
  assign mfault_c = dat_i[3:1] >= `DEK_MODE_LIST && !dat_i[4];
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
  assign w0_c = {col_r_ff, col_w_ff, seg_full_ff, fmt_full_ff, dfmt_ff, 1'b0,
                 rd_nm_ff[15:8]};
  assign w1_c = {8'h00, rd_nm_ff[7:0]};
  assign w2_c = {seg_ff, wr_nm_ff[15:8]};
  assign w3_c = {8'h00, wr_nm_ff[7:0]};

  always_comb begin
    unique case (adr_i)
      `DEK_A_CTRL: rd_c = {19'h0, loc_ff, 3'h0, list_ff, mode_ff, 1'b0};
      `DEK_A_STAT: rd_c = {17'h0, state_ff, et_ff, csp_ff, ofault_ff, mfault_ff,
                           afault_ff, done_s_ff, busy};
      `DEK_A_BIDX: rd_c = {27'h0, bidx_ff};
      `DEK_A_CST: rd_c = as_top[`DEK_S_CST];
      `DEK_A_CLN: rd_c = as_top[`DEK_S_CLN];
      `DEK_A_COL01: rd_c = {w0_c, w1_c};
      `DEK_A_COL23: rd_c = {w2_c, w3_c};
      `DEK_A_ECR: rd_c = {6'h00, ctl_ff};
      default: rd_c = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= wb_req && !ack_ff;
      if (wb_req && !ack_ff) begin
        dat_ff <= we_i ? 32'h00000000 : rd_c;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_ff <= 3'h0;
      list_ff <= 1'b0;
      loc_ff <= 5'h00;
      bidx_ff <= 5'h00;
    end else if (wb_wr) begin
      if (adr_i == `DEK_A_CTRL && sel_i[0] && state_ff == dek_pkg::S_IDLE) begin
        mode_ff <= dat_i[3:1];
        list_ff <= dat_i[4];
      end
      if (adr_i == `DEK_A_CTRL && sel_i[1] && state_ff == dek_pkg::S_IDLE) begin
        loc_ff <= dat_i[12:8];
      end
      if (adr_i == `DEK_A_BIDX && sel_i[0]) begin
        bidx_ff <= dat_i[4:0];
      end
    end
  end

  // Software preloads descriptors one 32-bit lane at a time; no reset on memory.
  always_ff @(posedge clk) begin
    if (wb_wr && adr_i[7:4] == `DEK_A_BUF) begin
      bmem[bidx_ff][adr_i[3:2]*32 +: 32] <= wmask(bmem[bidx_ff][adr_i[3:2]*32 +: 32],
                                                  dat_i, sel_i);
    end
  end

  // Sticky status: a hardware set in the cycle of a clear wins.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_s_ff <= 1'b0;
      afault_ff <= 1'b0;
      mfault_ff <= 1'b0;
      ofault_ff <= 1'b0;
    end else begin
      done_s_ff <= done || (done_s_ff && !(wb_wr && adr_i == `DEK_A_STAT && dat_i[1]));
      mfault_ff <= (start_go && mfault_c)
                   || (mfault_ff && !(wb_wr && adr_i == `DEK_A_STAT && dat_i[3]));
      afault_ff <= (state_ff == dek_pkg::S_ATTR && !f_se[0])
                   || (afault_ff && !(wb_wr && adr_i == `DEK_A_STAT && dat_i[2]));
      ofault_ff <= call_ovf_c
                   || (ofault_ff && !(wb_wr && adr_i == `DEK_A_STAT && dat_i[4]));
    end
  end

  // ****************************************
  // Field unpack
  // ****************************************
  always_comb begin
    f_hdr = fld(desc_ff, 7'h00, `DEK_HDR_W);
    f_ll = fld(desc_ff, 7'h06, 6'h02);
    unique case (f_hdr[1:0])
      `DEK_AT_DESC: alen_c = 7'h04;
      `DEK_AT_PROG: alen_c = 7'h0C + {3'h0, f_ll[1:0], 2'h0};
      default: alen_c = 7'h08;
    endcase
    p_wr_c = alen_c + (f_hdr[3] ? 7'h10 : 7'h00);
    p_se_c = p_wr_c + (f_hdr[2] ? 7'h10 : 7'h00);
    f_rd = fld(desc_ff, alen_c, `DEK_NAME_W);
    f_wr = fld(desc_ff, p_wr_c, `DEK_NAME_W);
    f_se = fld(desc_ff, p_se_c, `DEK_HDR_W);
    f_et = fld(desc_ff, ctl_ff.ptr, `DEK_HDR_W);
    f_seg = fld(desc_ff, ctl_ff.ptr + 7'h04, `DEK_SEG_W);
    f_nm = fld(desc_ff, ctl_ff.ptr + 7'h04, `DEK_NAME_W);
    plen_c = {1'b0, ({1'b0, ctl_ff.pfl} + 4'h1), 1'b0} << 1;
    f_es = fld(desc_ff, ctl_ff.ptr + 7'h04, plen_c);
    f_el = fld(desc_ff, ctl_ff.ptr + 7'h04 + {1'b0, plen_c}, plen_c);
  end

  assign generic_c = state_ff == dek_pkg::S_EXPR && f_et[3:0] != `DEK_ET_END
                     && f_et[3:0] != `DEK_ET_SEG && f_et[3:0] != `DEK_ET_CALL;
  assign branch_c = state_ff == dek_pkg::S_TERM && ctl_ff.atype == `DEK_AT_DESC;
  assign call_ovf_c = state_ff == dek_pkg::S_EXPR && f_et[3:0] == `DEK_ET_CALL
                      && csp_ff == `DEK_CS_DEPTH;
  assign busy = state_ff != dek_pkg::S_IDLE;

  // ****************************************
  // Evaluation sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= dek_pkg::S_IDLE;
      ctl_ff <= '0;
      csp_ff <= 3'h0;
      first_ff <= 1'b0;
      et_ff <= 4'h0;
      desc_ff <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_ff)
        dek_pkg::S_IDLE: begin
          if (start_go && !mfault_c) begin
            ctl_ff <= '0;
            ctl_ff.idx <= dat_i[12:8];
            csp_ff <= 3'h0;
            first_ff <= 1'b1;
            state_ff <= dek_pkg::S_FETCH;
          end else if (start_go) begin
            done <= 1'b1;
          end
        end
        dek_pkg::S_FETCH: begin
          desc_ff <= bmem[ctl_ff.idx];
          state_ff <= ctl_ff.ptr == 7'h00 ? dek_pkg::S_ATTR : dek_pkg::S_EXPR;
        end
        dek_pkg::S_ATTR: begin
          if (first_ff) begin
            ctl_ff.atype <= f_hdr[1:0];
            ctl_ff.abits <= 8'(fld(desc_ff, 7'h04, 6'h08));
          end
          first_ff <= 1'b0;
          ctl_ff.pfl <= f_se[3:1];
          ctl_ff.alloc <= f_se[0];
          ctl_ff.ptr <= p_se_c + 7'h04;
          if (!f_se[0]) begin
            state_ff <= dek_pkg::S_IDLE;
            done <= 1'b1;
          end else begin
            state_ff <= dek_pkg::S_EXPR;
          end
        end
        dek_pkg::S_EXPR: begin
          et_ff <= f_et[3:0];
          if (f_et[3:0] == `DEK_ET_END) begin
            state_ff <= dek_pkg::S_POP;
          end else if (f_et[3:0] == `DEK_ET_SEG) begin
            ctl_ff.ptr <= ctl_ff.ptr + 7'h0C;
          end else if (call_ovf_c) begin
            state_ff <= dek_pkg::S_IDLE;
            done <= 1'b1;
          end else if (f_et[3:0] == `DEK_ET_CALL) begin
            cstk_ff[csp_ff[1:0]] <= ctl_ff;
            cstk_ff[csp_ff[1:0]].ptr <= ctl_ff.ptr + 7'h14;
            csp_ff <= csp_ff + 3'h1;
            ctl_ff.idx <= f_nm[4:0];
            ctl_ff.ptr <= 7'h00;
            state_ff <= dek_pkg::S_FETCH;
          end else begin
            ctl_ff.ptr <= ctl_ff.ptr + 7'h04 + {plen_c, 1'b0};
            state_ff <= dek_pkg::S_AU;
          end
        end
        dek_pkg::S_AU: begin
          if (au_ack) begin
            state_ff <= dek_pkg::S_EXPR;
          end
        end
        dek_pkg::S_POP: begin
          if (csp_ff == 3'h0) begin
            state_ff <= dek_pkg::S_TERM;
          end else begin
            ctl_ff <= cstk_ff[csp_ff[1:0] - 2'h1];
            csp_ff <= csp_ff - 3'h1;
            state_ff <= dek_pkg::S_FETCH;
          end
        end
        dek_pkg::S_TERM: begin
          if (branch_c) begin
            ctl_ff.idx <= as_top[`DEK_S_CST][4:0];
            ctl_ff.ptr <= 7'h00;
            first_ff <= 1'b1;
            state_ff <= dek_pkg::S_FETCH;
          end else begin
            state_ff <= dek_pkg::S_IDLE;
            done <= 1'b1;
          end
        end
        default: state_ff <= dek_pkg::S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Attribute collection stack
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst || start_go) begin
      col_r_ff <= 1'b0;
      col_w_ff <= 1'b0;
      seg_full_ff <= 1'b0;
      fmt_full_ff <= 1'b0;
      dfmt_ff <= 3'h0;
      seg_ff <= 8'h00;
      rd_nm_ff <= 16'h0000;
      wr_nm_ff <= 16'h0000;
    end else if (branch_c) begin
      col_r_ff <= 1'b0;
      col_w_ff <= 1'b0;
      rd_nm_ff <= 16'h0000;
      wr_nm_ff <= 16'h0000;
    end else if (state_ff == dek_pkg::S_ATTR) begin
      if (f_hdr[3]) begin
        col_r_ff <= 1'b1;
        rd_nm_ff <= f_rd[15:0];
      end
      if (f_hdr[2]) begin
        col_w_ff <= 1'b1;
        wr_nm_ff <= f_wr[15:0];
      end
      if (f_hdr[0] && f_ll[0] == 1'b0 && !fmt_full_ff
          && fld(desc_ff, 7'h05, 6'h03) != 32'h00000000) begin
        fmt_full_ff <= 1'b1;
        dfmt_ff <= 3'(fld(desc_ff, 7'h05, 6'h03));
      end
    end else if (state_ff == dek_pkg::S_EXPR && f_et[3:0] == `DEK_ET_SEG
                 && !seg_full_ff) begin
      seg_full_ff <= 1'b1;
      seg_ff <= f_seg[7:0];
    end
  end

  // ****************************************
  // Attribute arithmetic stacks
  // ****************************************
  always_comb begin
    as_push = 4'h0;
    as_pop = 4'h0;
    as_wtop = 4'h0;
    as_din[`DEK_S_CST] = au_res;
    as_din[`DEK_S_CLN] = as_top[`DEK_S_ELN];
    as_din[`DEK_S_EST] = f_es;
    as_din[`DEK_S_ELN] = f_el;
    if (generic_c) begin
      as_push = 4'hC;
    end else if (state_ff == dek_pkg::S_AU && au_ack) begin
      as_pop = 4'hC;
      as_push = as_sp[`DEK_S_CST] == 3'h0 ? 4'h3 : 4'h0;
      as_wtop = as_sp[`DEK_S_CST] == 3'h0 ? 4'h0 : 4'h3;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_as
    logic [31:0] mem [0:3];
    logic [2:0] sp_ff;
    assign as_sp[i] = sp_ff;
    assign as_top[i] = sp_ff == 3'h0 ? 32'h00000000 : mem[sp_ff[1:0] - 2'h1];
    always_ff @(posedge clk) begin
      if (!nrst || start_go || branch_c) begin
        sp_ff <= 3'h0;
      end else if (as_push[i] && sp_ff != `DEK_AS_DEPTH) begin
        mem[sp_ff[1:0]] <= as_din[i];
        sp_ff <= sp_ff + 3'h1;
      end else if (as_wtop[i] && sp_ff != 3'h0) begin
        mem[sp_ff[1:0] - 2'h1] <= as_din[i];
      end else if (as_pop[i] && sp_ff != 3'h0) begin
        sp_ff <= sp_ff - 3'h1;
      end
    end
  end

  // ****************************************
  // Arithmetic unit, fault calls, terminal reference
  // ****************************************
  assign au_req = state_ff == dek_pkg::S_AU;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      au_op <= 3'h0;
      au_a <= 32'h00000000;
      au_b <= 32'h00000000;
    end else if (generic_c) begin
      au_op <= mode_ff;
      au_a <= as_top[`DEK_S_CST];
      au_b <= f_es;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_call <= 1'b0;
      fault_name <= 16'h0000;
    end else begin
      fault_call <= 1'b0;
      if (branch_c && (col_r_ff || col_w_ff)) begin
        fault_call <= 1'b1;
        fault_name <= col_r_ff ? rd_nm_ff : wr_nm_ff;
      end else if (l1_acc && !branch_c && ((l1_wr && col_w_ff) || (!l1_wr && col_r_ff))) begin
        fault_call <= 1'b1;
        fault_name <= l1_wr ? wr_nm_ff : rd_nm_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      term_valid <= 1'b0;
      term_ref <= '0;
    end else begin
      term_valid <= state_ff == dek_pkg::S_TERM && !branch_c;
      if (state_ff == dek_pkg::S_TERM && !branch_c) begin
        term_ref <= {as_top[`DEK_S_CST], as_top[`DEK_S_CLN], w0_c, w2_c,
                     ctl_ff.atype, ctl_ff.abits};
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  ack_one_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
    ack_o |=> !ack_o) else $error("ack held longer than one cycle");
  ack_response_a: assert property (@(posedge clk) disable iff (!nrst)
    wb_req && !ack_o |=> ack_o) else $error("ack missing after request");
  fetch_first_a: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_FETCH && ctl_ff.ptr == 7'h00 |=> state_ff == dek_pkg::S_ATTR)
    else $error("fetch not followed by attribute decode");
  list_only_a: assert property (@(posedge clk) disable iff (!nrst)
    start_go && mfault_c |=> mfault_ff && !busy) else $error("list mode accepted");
  alloc_halt_a: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_ATTR && !f_se[0] |=> afault_ff && done && !busy)
    else $error("allocate fault not raised");
  first_attr_a: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_ATTR && !first_ff |=> $stable(ctl_ff.atype))
    else $error("nested attributes overwrote first");
  seg_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_EXPR && f_et[3:0] == `DEK_ET_SEG && seg_full_ff |=> $stable(seg_ff))
    else $error("full segment entry overwritten");
  call_push_a: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_EXPR && f_et[3:0] == `DEK_ET_CALL && !call_ovf_c
    |=> csp_ff == $past(csp_ff) + 3'h1 && state_ff == dek_pkg::S_FETCH)
    else $error("call did not nest");
  branch_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    branch_c |=> !col_r_ff && !col_w_ff && state_ff == dek_pkg::S_FETCH)
    else $error("branch left fault entries");
  elem_drain_a: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_AU && au_ack |=> as_sp[`DEK_S_EST] == $past(as_sp[`DEK_S_EST]) - 3'h1)
    else $error("element stack not drained");
  type_load_a: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_EXPR |=> et_ff == $past(f_et[3:0])) else $error("type not loaded");
  term_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    term_valid |-> !busy && done) else $error("terminal reference while busy");
  term_cover_c: cover property (@(posedge clk) disable iff (!nrst) term_valid);
  call_cover_c: cover property (@(posedge clk) disable iff (!nrst)
    state_ff == dek_pkg::S_POP && csp_ff != 3'h0);
  branch_cover_c: cover property (@(posedge clk) disable iff (!nrst) branch_c && fault_call == 1'b0);
  afault_cover_c: cover property (@(posedge clk) disable iff (!nrst) $rose(afault_ff));
endmodule : dek_kernel

// file: rtl/dek_pkg.sv
/*
 Types of the descriptor evaluation kernel: states, control entry, terminal reference.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dek_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_FETCH = 3'h1, S_ATTR = 3'h2, S_EXPR = 3'h3,
    S_AU = 3'h4, S_POP = 3'h5, S_TERM = 3'h6
  } dek_state_e;
  typedef struct packed {
    logic [4:0] idx;
    logic [6:0] ptr;
    logic [1:0] atype;
    logic [7:0] abits;
    logic [2:0] pfl;
    logic alloc;
  } dek_ctl_s;
  typedef struct packed {
    logic [31:0] cst;
    logic [31:0] cln;
    logic [15:0] col0;
    logic [15:0] col2;
    logic [1:0] atype;
    logic [7:0] abits;
  } dek_term_s;
endpackage : dek_pkg
